// File: design/wpf_map.vh
`ifndef WPF_MAP_VH
`define WPF_MAP_VH
// Pattern window and capture depth in bytes.
`define WPF_WIN_BYTES     128
`define WPF_NUM_FILTERS   4
// Protocol constants used by the fixed checks.
`define WPF_TYPE_IPX      16'h8137
`define WPF_IPX_DIAG_SOCK 16'h0456
`define WPF_TYPE_IPV6     16'h86DD
`define WPF_IPV6_VER      4'h6
`define WPF_NH_ICMP       8'h3A
`define WPF_NH_HOP        8'h00
`define WPF_NH_ROUTE      8'h2B
`define WPF_NH_DEST       8'h3C
`define WPF_HOP_ALL       8'hFF
`define WPF_ICMP_NS       8'h87
`define WPF_ICMP_CODE0    8'h00
// Base offsets before the tag and LLC/SNAP adjustments.
`define WPF_OFF_TYPE      8'h0C
`define WPF_OFF_IPX_NODE  8'h18
`define WPF_OFF_IPX_SOCK  8'h1E
`define WPF_OFF_V6_VER    8'h0E
`define WPF_OFF_V6_NH     8'h14
`define WPF_OFF_V6_HOP    8'h15
`define WPF_OFF_V6_EXT    8'h36
`define WPF_VLAN_LEN      8'h04
`define WPF_SNAP_LEN      8'h08
`endif

// File: design/wpf_buf.v
`timescale 1ns/100ps
// Wakeup packet buffer: 128 bytes, registered read data.
module wpf_buf (
	input  wire       clk_in,
	input  wire       we_in,
	input  wire [6:0] waddr_in,
	input  wire [7:0] wdata_in,
	input  wire [6:0] raddr_in,
	output reg  [7:0] rdata_out
);
	reg [7:0] mem [0:127];

	// Write port fed by the capture logic; read port by host software.
	always @(posedge clk_in) begin
		if (we_in)
			mem[waddr_in] <= wdata_in;
		rdata_out <= mem[raddr_in];
	end
endmodule // wpf_buf

// File: design/wpf_top.v
`timescale 1ns/100ps
`include "wpf_map.vh"
module wpf_top (
	input  wire         SYS_CLK_IN,
	input  wire         RST_IN,
	input  wire         RX_VALID_IN,
	input  wire [7:0]   RX_DATA_IN,
	input  wire         RX_SOF_IN,
	input  wire         RX_EOF_IN,
	input  wire         RX_FCS_OK_IN,
	input  wire [3:0]   FILTER_EN_IN,
	input  wire         IPX_DIAG_EN_IN,
	input  wire         IPX_DIR_EN_IN,
	input  wire         NS_EN_IN,
	input  wire         VLAN_PRESENT_IN,
	input  wire         SNAP_PRESENT_IN,
	input  wire [47:0]  STATION_ADDR_IN,
	input  wire [127:0] IPV6_ADDRESS_ENTRY_ZERO_IN,
	input  wire [511:0] FLEX_FILTER_MASK_TABLE_IN,
	input  wire [4095:0] FLEX_FILTER_VALUE_TABLE_IN,
	input  wire [31:0]  FLEX_FILTER_LENGTH_TABLE_IN,
	input  wire [6:0]   WAKEUP_PACKET_BUFFER_RADDR_IN,
	output wire [7:0]   WAKEUP_PACKET_BUFFER_DATA_OUT,
	output reg  [6:0]   WAKEUP_STATUS_OUT,
	output reg  [7:0]   WAKEUP_LEN_OUT,
	output reg          WAKEUP_EVENT_OUT
);
	// Receive stream is in the same clock domain; tables are quasi-static.
	reg  [7:0] pos_r;
	reg  [3:0] flex_fail_r;
	reg  [3:0] flex_pass_r;
	reg        ipx_type_r, ipx_sock_r, ipx_node_r;
	reg        ns_ok_r, ns_tgt_r;
	reg  [7:0] ext_off_r;
	reg  [7:0] nh_r;
	reg        in_ext_r;
	reg  [7:0] tgt_off_r;
	reg        ns_icmp_seen_r;
	reg  [7:0] capt_cnt_r;
	reg        stored_r;
	wire [7:0] adj;
	wire       in_frame;
	wire [6:0] cap_addr;
	wire       cap_we;
	integer    i;
	reg  [3:0] flex_fail_now;
	reg  [3:0] flex_pass_now;
	wire [3:0] fail_base;
	wire [3:0] pass_base;
	wire [3:0] flex_hit;
	wire       ipx_diag_hit;
	wire       ipx_dir_hit;
	wire       ns_hit;
	localparam [15:0] type_ipx  = `WPF_TYPE_IPX;
	localparam [15:0] diag_sock = `WPF_IPX_DIAG_SOCK;
	localparam [15:0] type_ipv6 = `WPF_TYPE_IPV6;

	// Optional header lengths supplied by software, not detected here; only the fixed checks skip them.
	assign adj = (VLAN_PRESENT_IN ? `WPF_VLAN_LEN : 8'h00) +
		(SNAP_PRESENT_IN ? `WPF_SNAP_LEN : 8'h00);
	assign in_frame = RX_VALID_IN;

	// Flexible filters judge the current byte combinationally, so the
	// last byte of a frame counts before the end-of-frame decision.
	always @* begin
		flex_fail_now = 4'h0;
		flex_pass_now = 4'h0;
		for (i = 0; i < `WPF_NUM_FILTERS; i = i + 1) begin
			if (pos_r < 8'd128 &&
			    pos_r < FLEX_FILTER_LENGTH_TABLE_IN[i*8 +: 8] &&
			    FLEX_FILTER_MASK_TABLE_IN[i*128 + pos_r] &&
			    RX_DATA_IN !=
			    FLEX_FILTER_VALUE_TABLE_IN[(i*128+pos_r)*8 +: 8])
				flex_fail_now[i] = 1'b1;
			if (FLEX_FILTER_LENGTH_TABLE_IN[i*8 +: 8] != 8'h00 &&
			    pos_r + 8'h01 == FLEX_FILTER_LENGTH_TABLE_IN[i*8 +: 8])
				flex_pass_now[i] = 1'b1;
		end
	end

	// A frame that starts now inherits no flexible filter verdict from the previous one.
	assign fail_base = RX_SOF_IN ? 4'h0 : flex_fail_r;
	assign pass_base = RX_SOF_IN ? 4'h0 : flex_pass_r;
	assign flex_hit  = FILTER_EN_IN & (pass_base | flex_pass_now) &
		~(fail_base | flex_fail_now);
	assign ipx_diag_hit = IPX_DIAG_EN_IN && ipx_type_r && ipx_sock_r;
	assign ipx_dir_hit  = IPX_DIR_EN_IN && ipx_type_r && ipx_node_r;
	// The whole target must have gone by before the frame ends.
	assign ns_hit = NS_EN_IN && ns_ok_r && ns_tgt_r && ns_icmp_seen_r &&
		(pos_r > tgt_off_r + 8'h0F);

	function is_ext;
		input [7:0] nh;
		begin
			is_ext = (nh == `WPF_NH_HOP) || (nh == `WPF_NH_ROUTE) ||
				(nh == `WPF_NH_DEST);
		end
	endfunction

	function [7:0] sel_byte;
		input [127:0] v;
		input [7:0]   idx;
		begin
			sel_byte = v[8'd127 - {idx[3:0], 3'b000} -: 8];
		end
	endfunction

	// Capture into a shadow area would need a second buffer; instead the
	// buffer is written only while no wakeup capture is stored.
	// The trade-off: a failing frame may corrupt bytes of an unclaimed
	// capture, so capture is held off once a valid wakeup is stored.
	assign cap_we   = in_frame && !stored_r && (pos_r < 8'd128);
	assign cap_addr = pos_r[6:0];

	wpf_buf u_wpf_buf (
		.clk_in   (SYS_CLK_IN),
		.we_in    (cap_we),
		.waddr_in (cap_addr),
		.wdata_in (RX_DATA_IN),
		.raddr_in (WAKEUP_PACKET_BUFFER_RADDR_IN),
		.rdata_out(WAKEUP_PACKET_BUFFER_DATA_OUT)
	);

	// Per-byte matcher walking the frame from its first byte.
	always @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			pos_r <= 8'h00;
			flex_fail_r <= 4'h0;
			flex_pass_r <= 4'h0;
			ipx_type_r <= 1'b0;
			ipx_sock_r <= 1'b0;
			ipx_node_r <= 1'b0;
			ns_ok_r <= 1'b0;
			ns_tgt_r <= 1'b0;
			ext_off_r <= 8'h00;
			nh_r <= 8'h00;
			in_ext_r <= 1'b0;
			tgt_off_r <= 8'h00;
			ns_icmp_seen_r <= 1'b0;
			capt_cnt_r <= 8'h00;
			stored_r <= 1'b0;
			WAKEUP_STATUS_OUT <= 7'h00;
			WAKEUP_LEN_OUT <= 8'h00;
			WAKEUP_EVENT_OUT <= 1'b0;
		end else begin
			WAKEUP_EVENT_OUT <= 1'b0;
			if (RX_SOF_IN) begin
				pos_r <= 8'h00;
				flex_fail_r <= 4'h0;
				flex_pass_r <= 4'h0;
				ipx_type_r <= 1'b0;
				ipx_sock_r <= 1'b0;
				ipx_node_r <= 1'b1;
				ns_ok_r <= 1'b1;
				ns_tgt_r <= 1'b1;
				in_ext_r <= 1'b0;
				ns_icmp_seen_r <= 1'b0;
				capt_cnt_r <= 8'h00;
			end
			if (in_frame) begin
				// The count restarts after the last byte, so the next
				// frame's first byte always sits at position zero.
				if (RX_EOF_IN)
					pos_r <= 8'h00;
				else if (pos_r != 8'hFF)
					pos_r <= pos_r + 8'h01;
				if (pos_r < 8'd128)
					capt_cnt_r <= pos_r + 8'h01;
				// Flexible filters accumulate the per-byte verdicts.
				flex_fail_r <= fail_base | flex_fail_now;
				flex_pass_r <= pass_base | flex_pass_now;
				// Fixed type field, both bytes.
				if (pos_r == `WPF_OFF_TYPE + adj)
					ipx_type_r <= RX_DATA_IN == type_ipx[15:8];
				if (pos_r == `WPF_OFF_TYPE + adj + 8'h01)
					ipx_type_r <= ipx_type_r &&
						RX_DATA_IN == type_ipx[7:0];
				if (pos_r == `WPF_OFF_IPX_SOCK + adj)
					ipx_sock_r <= RX_DATA_IN == diag_sock[15:8];
				if (pos_r == `WPF_OFF_IPX_SOCK + adj + 8'h01)
					ipx_sock_r <= ipx_sock_r &&
						RX_DATA_IN == diag_sock[7:0];
				if (pos_r >= `WPF_OFF_IPX_NODE + adj &&
				    pos_r < `WPF_OFF_IPX_NODE + adj + 8'h06 &&
				    RX_DATA_IN != STATION_ADDR_IN[8'd47 -
				    {pos_r - `WPF_OFF_IPX_NODE - adj, 3'b000} -: 8])
					ipx_node_r <= 1'b0;
				// Neighbor solicitation header walk.
				if ((pos_r == `WPF_OFF_TYPE + adj &&
				     RX_DATA_IN != type_ipv6[15:8]) ||
				    (pos_r == `WPF_OFF_TYPE + adj + 8'h01 &&
				     RX_DATA_IN != type_ipv6[7:0]) ||
				    (pos_r == `WPF_OFF_V6_VER + adj &&
				     RX_DATA_IN[7:4] != `WPF_IPV6_VER) ||
				    (pos_r == `WPF_OFF_V6_HOP + adj &&
				     RX_DATA_IN != `WPF_HOP_ALL))
					ns_ok_r <= 1'b0;
				if (pos_r == `WPF_OFF_V6_NH + adj) begin
					nh_r <= RX_DATA_IN;
					if (RX_DATA_IN != `WPF_NH_ICMP && !is_ext(RX_DATA_IN))
						ns_ok_r <= 1'b0;
					ext_off_r <= `WPF_OFF_V6_EXT + adj;
				end
				if (pos_r == ext_off_r && pos_r > `WPF_OFF_V6_NH + adj &&
				    !ns_icmp_seen_r) begin
					if (is_ext(nh_r)) begin
						nh_r <= RX_DATA_IN;
						in_ext_r <= 1'b1;
					end else begin
						if (RX_DATA_IN != `WPF_ICMP_NS)
							ns_ok_r <= 1'b0;
						ns_icmp_seen_r <= 1'b1;
						tgt_off_r <= pos_r + 8'd8;
					end
				end
				// Extension length byte: (n+1)*8 octets per header.
				if (in_ext_r && pos_r == ext_off_r + 8'h01) begin
					ext_off_r <= ext_off_r +
						{RX_DATA_IN[4:0], 3'b000} + 8'h08;
					in_ext_r <= 1'b0;
					if (!is_ext(nh_r) && nh_r != `WPF_NH_ICMP)
						ns_ok_r <= 1'b0;
				end
				if (ns_icmp_seen_r && pos_r == tgt_off_r - 8'd7 &&
				    RX_DATA_IN != `WPF_ICMP_CODE0)
					ns_ok_r <= 1'b0;
				if (ns_icmp_seen_r && pos_r >= tgt_off_r &&
				    pos_r < tgt_off_r + 8'd16 &&
				    RX_DATA_IN != sel_byte(IPV6_ADDRESS_ENTRY_ZERO_IN,
				    pos_r - tgt_off_r))
					ns_tgt_r <= 1'b0;
			end
			// End of frame: raise wakeup only if the FCS is good.
			if (in_frame && RX_EOF_IN) begin
				if (RX_FCS_OK_IN && !stored_r &&
				    (|flex_hit || ipx_diag_hit || ipx_dir_hit ||
				     ns_hit)) begin
					stored_r <= 1'b1;
					WAKEUP_EVENT_OUT <= 1'b1;
					// The last byte has not reached the count yet.
					WAKEUP_LEN_OUT <= (pos_r < 8'd128) ?
						pos_r + 8'h01 : capt_cnt_r;
					WAKEUP_STATUS_OUT <= {ns_hit, ipx_dir_hit,
						ipx_diag_hit, flex_hit};
				end
			end
		end
	end
endmodule // wpf_top

// File: verification/wpf_props.sv
`timescale 1ns/100ps
// Ties the wakeup outputs to the received frame ends and the enables.
module wpf_props (
	input wire       SYS_CLK_IN,
	input wire       RST_IN,
	input wire       RX_VALID_IN,
	input wire       RX_EOF_IN,
	input wire       RX_FCS_OK_IN,
	input wire [3:0] FILTER_EN_IN,
	input wire       IPX_DIAG_EN_IN,
	input wire       IPX_DIR_EN_IN,
	input wire       NS_EN_IN,
	input wire [6:0] WAKEUP_STATUS_OUT,
	input wire [7:0] WAKEUP_LEN_OUT,
	input wire       WAKEUP_EVENT_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);
	// Last byte of a frame, with its check sequence verdict.
	sequence s_end(ok);
		RX_VALID_IN && RX_EOF_IN && RX_FCS_OK_IN == ok;
	endsequence
	a_bad_fcs_quiet: assert property (
		s_end(1'b0) |=> !WAKEUP_EVENT_OUT) else $error("event on bad frame");
	a_event_after_end: assert property (
		WAKEUP_EVENT_OUT |-> $past(RX_VALID_IN && RX_EOF_IN && RX_FCS_OK_IN))
		else $error("event without good frame end");
	a_event_one_shot: assert property (
		WAKEUP_EVENT_OUT |=> !WAKEUP_EVENT_OUT [*8]) else $error("event repeats");
	a_len_in_range: assert property (
		WAKEUP_EVENT_OUT |-> WAKEUP_LEN_OUT != 0 && WAKEUP_LEN_OUT <= 8'd128)
		else $error("stored length out of range");
	a_store_holds: assert property (
		WAKEUP_STATUS_OUT != 0 |=> $stable(WAKEUP_STATUS_OUT)
		&& $stable(WAKEUP_LEN_OUT)) else $error("stored status changed");
	a_event_has_cause: assert property (
		WAKEUP_EVENT_OUT |-> WAKEUP_STATUS_OUT != 0
		&& $past(WAKEUP_STATUS_OUT) == 0) else $error("event status wrong");
	a_only_enabled: assert property (
		WAKEUP_EVENT_OUT |-> (WAKEUP_STATUS_OUT & ~{NS_EN_IN, IPX_DIR_EN_IN,
		IPX_DIAG_EN_IN, FILTER_EN_IN}) == 0) else $error("disabled detector hit");
	a_status_with_event: assert property (
		$changed(WAKEUP_STATUS_OUT) |-> WAKEUP_EVENT_OUT)
		else $error("status moved without event");
endmodule // wpf_props
bind wpf_top wpf_props u_props (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
	.RX_VALID_IN(RX_VALID_IN), .RX_EOF_IN(RX_EOF_IN),
	.RX_FCS_OK_IN(RX_FCS_OK_IN), .FILTER_EN_IN(FILTER_EN_IN),
	.IPX_DIAG_EN_IN(IPX_DIAG_EN_IN), .IPX_DIR_EN_IN(IPX_DIR_EN_IN),
	.NS_EN_IN(NS_EN_IN), .WAKEUP_STATUS_OUT(WAKEUP_STATUS_OUT),
	.WAKEUP_LEN_OUT(WAKEUP_LEN_OUT), .WAKEUP_EVENT_OUT(WAKEUP_EVENT_OUT));

// File: verification/wpf_station.sv
`timescale 1ns/100ps
// Remote station: plays a frame one byte a cycle off the falling edge.
module wpf_station (
	input  wire       clk_in,
	output reg        valid_out,
	output reg  [7:0] data_out,
	output reg        sof_out,
	output reg        eof_out,
	output reg        fcs_ok_out
);
	reg [7:0] frm [0:255];
	integer   i;
	initial {valid_out, sof_out, eof_out, fcs_ok_out, data_out} = 12'h000;
	// Idle data is the inverse of the last byte, so stale data never matches.
	task send(input integer n, input ok);
		for (i = 0; i < n; i = i + 1) begin
			@(negedge clk_in);
			valid_out = 1'b1;
			data_out = frm[i];
			sof_out = (i == 0);
			eof_out = (i == n - 1);
			fcs_ok_out = ok;
		end
		@(negedge clk_in);
		{valid_out, sof_out, eof_out, fcs_ok_out} = 4'h0;
		data_out = ~data_out;
	endtask
endmodule // wpf_station

// File: verification/wakeup_pattern_filter_store_test.sv
`timescale 1ns/100ps
module wakeup_pattern_filter_store_test;
	reg           clk = 1'b0;
	reg           rst = 1'b1;
	reg  [3:0]    fen = 4'h0;
	reg  [2:0]    xen = 3'h0;
	reg  [1:0]    hdr = 2'h0;
	reg  [47:0]   sta = 0;
	reg  [127:0]  v6a = 0;
	reg  [511:0]  msk = 0;
	reg  [4095:0] val = 0;
	reg  [31:0]   lnt = 0;
	reg  [6:0]    ra = 7'h00;
	reg  [7:0]    es, fr [0:255], q [0:127];
	reg           seen, ok;
	wire [7:0]    rd, wlen, rdat;
	wire [6:0]    wst;
	wire          wev, rv, rs, re, rok;
	integer       bad_count = 0;
	integer       comparisons = 0;
	integer       seed = 2795;
	integer       t, n, f, k, o, ln, el, p, nx;
	wpf_station u_station (.clk_in(clk), .valid_out(rv), .data_out(rdat),
		.sof_out(rs), .eof_out(re), .fcs_ok_out(rok));
	wpf_top u_wpf_top (.SYS_CLK_IN(clk), .RST_IN(rst), .RX_VALID_IN(rv),
		.RX_DATA_IN(rdat), .RX_SOF_IN(rs), .RX_EOF_IN(re), .RX_FCS_OK_IN(rok),
		.FILTER_EN_IN(fen), .IPX_DIAG_EN_IN(xen[0]), .IPX_DIR_EN_IN(xen[1]),
		.NS_EN_IN(xen[2]), .VLAN_PRESENT_IN(hdr[0]), .SNAP_PRESENT_IN(hdr[1]),
		.STATION_ADDR_IN(sta), .IPV6_ADDRESS_ENTRY_ZERO_IN(v6a),
		.FLEX_FILTER_MASK_TABLE_IN(msk), .FLEX_FILTER_VALUE_TABLE_IN(val),
		.FLEX_FILTER_LENGTH_TABLE_IN(lnt),
		.WAKEUP_PACKET_BUFFER_RADDR_IN(ra),
		.WAKEUP_PACKET_BUFFER_DATA_OUT(rd), .WAKEUP_STATUS_OUT(wst),
		.WAKEUP_LEN_OUT(wlen), .WAKEUP_EVENT_OUT(wev));
	always #20 clk = ~clk;
	// The event stands one cycle only, so it is latched where it settles.
	always @(negedge clk) if (wev === 1'b1) seen = 1'b1;
	task check(input [7:0] s, input [7:0] e);
		comparisons = comparisons + 1;
		if (s !== e) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("mismatches %0d of %0d compares", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task play(input g);
		seen = 1'b0;
		for (k = 0; k < 256; k = k + 1) u_station.frm[k] = fr[k];
		u_station.send(n, g);
		repeat (3) @(negedge clk);
	endtask
	// Reference detectors; offsets shift by tag and SNAP as software would.
	task model;
		es = 8'h00;
		for (f = 0; f < 4; f = f + 1) begin
			ln = lnt[f*8 +: 8];
			es[f] = fen[f] && ln != 0 && n >= ln;
			for (k = 0; k < ln; k = k + 1)
				if (msk[f*128+k] && fr[k] !== val[(f*128+k)*8 +: 8]) es[f] = 0;
		end
		if ({fr[o], fr[o+1]} == 16'h8137) begin
			es[4] = xen[0] && {fr[o+18], fr[o+19]} == 16'h0456;
			es[5] = xen[1] && {fr[o+12], fr[o+13], fr[o+14], fr[o+15],
				fr[o+16], fr[o+17]} == sta;
		end
		// Solicitation: walk extension headers to the ICMP part.
		if ({fr[o], fr[o+1]} == 16'h86DD && fr[o+2][7:4] == 4'h6 &&
		    fr[o+9] == 8'hFF) begin
			nx = fr[o+8];
			p = o + 42;
			for (k = 0; k < 4 && (nx == 0 || nx == 8'h2B || nx == 8'h3C);
			     k = k + 1) begin
				nx = fr[p];
				p = p + 8 * fr[p+1] + 8;
			end
			es[6] = xen[2] && nx == 8'h3A && fr[p] == 8'h87 &&
				fr[p+1] == 8'h00 && n > p + 24;
			for (k = 0; k < 16; k = k + 1)
				if (fr[p+8+k] != v6a[127-8*k -: 8]) es[6] = 1'b0;
		end
		if (!ok) es = 8'h00;
	endtask
	// Each trial resets, programs random tables and sends a frame, then its inverse.
	initial begin
		for (t = 0; t < 12; t = t + 1) begin
			rst = 1'b1;
			repeat (6) @(negedge clk);
			rst = 1'b0;
			hdr = t[1:0];
			fen = $random(seed);
			xen = $random(seed);
			ok = (t % 5 != 4);
			n = 48 + ($random(seed) & 127);
			sta = {$random(seed), $random(seed)};
			lnt = $random(seed) & 32'h7F7F_7F7F;
			o = 12 + 4 * hdr[0] + 8 * hdr[1];
			for (k = 0; k < 256; k = k + 1) fr[k] = $random(seed);
			if (t > 5) {fr[o], fr[o+1]} = 16'h8137;
			if (t[0]) {fr[o+18], fr[o+19]} = 16'h0456;
			for (k = 0; k < 6 && t[1]; k = k + 1) fr[o+12+k] = sta[47-8*k -: 8];
			// Every fourth trial is a solicitation, one behind a hop
			// header and the last with a wrong hop limit.
			v6a = {$random(seed), $random(seed)};
			v6a = {v6a[63:0], $random(seed), $random(seed)};
			if (t % 4 == 3) begin
				{fr[o], fr[o+1], fr[o+2], fr[o+9]} = 32'h86DD_60FF;
				fr[o+8] = (t == 7) ? 8'h00 : 8'h3A;
				p = (t == 7) ? o + 50 : o + 42;
				{fr[o+42], fr[o+43]} = 16'h3A00;
				{fr[p], fr[p+1]} = 16'h8700;
				for (k = 0; k < 16; k = k + 1)
					fr[p+8+k] = v6a[127-8*k -: 8];
				if (t == 11) fr[o+9] = 8'hFE;
				if (n < o + 76) n = o + 76;
				xen[2] = 1'b1;
			end
			for (k = 0; k < 16; k = k + 1)
				msk[k*32 +: 32] = $random(seed) & $random(seed) & $random(seed);
			for (k = 0; k < 512; k = k + 1)
				val[k*8 +: 8] = fr[k%128] ^ {7'h00, ($random(seed) & 31) == 0};
			model;
			play(ok);
			el = es != 0 ? (n < 128 ? n : 128) : 0;
			check({7'h00, seen}, {7'h00, es != 0});
			check({1'b0, wst}, es);
			check({7'h00, wst[6]}, {7'h00, es[6]});
			check(wlen, el[7:0]);
			for (k = 0; k < 128; k = k + 1) q[k] = fr[k];
			for (k = 0; k < 256; k = k + 1) fr[k] = ~fr[k];
			play(1'b1);
			if (es != 0) check({7'h00, seen}, 8'h00);
			for (k = 0; k < el; k = k + 1) begin
				ra = k;
				@(negedge clk);
				check(rd, q[k]);
			end
		end
		wrap_up;
	end
	// Trials take under six thousand cycles; this allows over eight times that.
	initial begin
		#2_000_000;
		bad_count = bad_count + 1;
		wrap_up;
	end
endmodule // wakeup_pattern_filter_store_test
